// ==== flash_array_model.sv ====
// Purpose: behavioural main array engine
// Assumes: one read in flight at a time
// Notes: accepts requests one clk late
module flash_array_model #(parameter integer OP_TIME = 400) (
   input wire clk_sys,
   input wire arst_n,
   input wire arrCmdValid,
   output reg arrCmdReady,
   input wire [2:0] arrCmdOp,
   input wire [11:0] arrCmdPage,
   input wire [8:0] arrCmdByte,
   input wire arrCmdBuf,
   output reg arrRdValid,
   input wire arrRdReady,
   output wire [7:0] arrRdData,
   output reg arrDone,
   output wire arrMismatch,
   output wire bufRdSel,
   output wire [8:0] bufRdAddr
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [7:0] rdByte;
   reg [1:0] rdCnt;
   reg [9:0] opCnt;
   reg [2:0] lastOp;
   reg [11:0] lastPage;
   reg lastBuf;
   reg [15:0] opCount;
   // Idle bus shows the inverse, never a stale copy
   assign arrRdData = arrRdValid ? rdByte : ~rdByte;
   assign arrMismatch = (lastOp == 3'h5);
   assign bufRdSel = 1'b0;
   assign bufRdAddr = 9'd262;
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         arrCmdReady <= 1'b0;
         arrRdValid <= 1'b0;
         arrDone <= 1'b0;
         rdByte <= 8'h00;
         rdCnt <= 2'd0;
         opCnt <= 10'd0;
         lastOp <= 3'h0;
         lastPage <= 12'h000;
         lastBuf <= 1'b0;
         opCount <= 16'h0000;
      end else begin
         // Late accept forces the core to hold its request
         arrCmdReady <= arrCmdValid && !arrCmdReady;
         arrDone <= (opCnt == 10'd1);
         if (opCnt != 10'd0)
            opCnt <= opCnt - 10'd1;
         if (rdCnt != 2'd0)
            rdCnt <= rdCnt - 2'd1;
         if (rdCnt == 2'd1)
            arrRdValid <= 1'b1;
         else if (arrRdReady)
            arrRdValid <= 1'b0;
         if (arrCmdValid && arrCmdReady) begin
            if (arrCmdOp == 3'h0) begin
               rdCnt <= 2'd2;
               rdByte <= arrCmdPage[7:0] + arrCmdByte[7:0];
            end else begin
               opCnt <= OP_TIME[9:0];
               lastOp <= arrCmdOp;
               lastPage <= arrCmdPage;
               lastBuf <= arrCmdBuf;
               opCount <= opCount + 16'h0001;
            end
         end
      end
   end
endmodule // flash_array_model

// ==== flash_core_asserts.sv ====
// Purpose: port checks for the serial flash command core
// Assumes: sck halves last at least 2 clk
// Notes: bound into every core instance
module flash_core_asserts (
   input wire clk_sys,
   input wire arst_n,
   input wire csN,
   input wire sck,
   input wire so,
   input wire soOe,
   input wire arrCmdValid,
   input wire arrCmdReady,
   input wire [2:0] arrCmdOp,
   input wire [11:0] arrCmdPage,
   input wire arrDone,
   input wire busy
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   property p_cs_release; $rose(csN) |-> ##2 !soOe; endproperty
   a_cs_release: assert property (p_cs_release) else $error("so kept after deselect");
   property p_cmd_hold;
      arrCmdValid && !arrCmdReady |=> arrCmdValid && $stable(arrCmdOp) && $stable(arrCmdPage);
   endproperty
   a_cmd_hold: assert property (p_cmd_hold) else $error("array request dropped");
   property p_busy_done; busy && arrDone |=> !busy; endproperty
   a_busy_done: assert property (p_busy_done) else $error("busy after done");
   property p_busy_stay; busy && !arrDone |=> busy; endproperty
   a_busy_stay: assert property (p_busy_stay) else $error("busy ended early");
   // Busy may lead the request by up to two clk or trail it by one
   property p_busy_cause; $rose(busy) |-> ##[0:2] (arrCmdValid || $past(arrCmdValid)); endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy without request");
   property p_op_after_cs; $rose(arrCmdValid) && arrCmdOp != 3'h0 |-> csN && $past(csN); endproperty
   a_op_after_cs: assert property (p_op_after_cs) else $error("op issued in frame");
   property p_oe_on; $rose(soOe) |-> !csN && !sck; endproperty
   a_oe_on: assert property (p_oe_on) else $error("so enabled off a fall");
   // Poll may see bit 7 flip with the clock halted high, one clk after busy falls
   property p_so_hold;
      soOe && $past(soOe) && sck && $past(sck) && !($past(busy, 2) && !$past(busy)) |-> $stable(so);
   endproperty
   a_so_hold: assert property (p_so_hold) else $error("so moved with sck high");
   property p_busy_fall; $fell(busy) |-> $past(arrDone); endproperty
   a_busy_fall: assert property (p_busy_fall) else $error("busy fell without done");
endmodule // flash_core_asserts

bind serial_flash_command_core flash_core_asserts chk (.clk_sys(clk_sys), .arst_n(arst_n), .csN(csN),
   .sck(sck), .so(so), .soOe(soOe), .arrCmdValid(arrCmdValid), .arrCmdReady(arrCmdReady),
   .arrCmdOp(arrCmdOp), .arrCmdPage(arrCmdPage), .arrDone(arrDone), .busy(busy));

// ==== serial_flash_command_core.v ====
// Purpose: command decoder and sequencer for a serial paged flash with two page buffers
// Assumes: csN, sck, si synchronous to clk_sys; sck well below clk_sys/4
// Notes: main array sits behind the arr* port; two SRAM buffers live here
// Summary of operation
// R01: Opcode 52H/D2H starts page read: 24 address bits then 32 dummy bits.
// R02: Page read address is 3 reserved, 12-bit page, 9-bit byte offset.
// R03: After the dummy bits, one output bit of page data per clock.
// R04: Page read wraps from the last byte to byte zero of same page.
// R05: Page reads fetch straight from the array, buffers untouched.
// R06: Host holds select low; select rising ends read, output released.
// R07: 54H/D4H reads buffer one, 56H/D6H reads buffer two.
// R08: Buffer read frame: opcode, 15 dummy, 9-bit address, 8 dummy, data.
// R09: Buffer read wraps past byte 263 back to address zero.
// R10: 57H/D7H shifts out the 8-bit status, MSB first.
// R11: Status repeats from bit 7 with fresh values while clocks continue.
// R12: Status bit 7 is one when ready, zero while busy.
// R13: Busy is entered only by the self-timed array operations.
// R14: Status bit 6 holds latest compare result, one on any mismatch.
// R15: Status bits 5..3 hold a fixed density code; low bits reserved.
// R16: 84H/87H write buffer one/two after 15 dummy and 9 address bits.
// R17: Buffer write stores at rising addresses, wraps, until select rises.
// R18: 83H/86H erase page then program it from buffer at select rising.
// R19: 88H/89H program page from buffer without erase; busy meanwhile.
// R20: 81H erases one page at select rising; busy until done.
// R21: 50H erases an aligned group of eight pages; busy meanwhile.
// R22: With clock halted on bit 7, output flips to one when busy ends.
// R23: Every command starts at select falling with an 8-bit opcode.
// R24: Opcodes, addresses and data travel MSB first.
// R25: Input sampled on clock rising, output changed on clock falling.
// R26: Host starts no array operation while another is running.
// R27: A program or erase frame cut short starts no operation.
`include "serial_flash_map.vh"

module serial_flash_command_core (
   input wire clk_sys,
   input wire arst_n,
   input wire csN,
   input wire sck,
   input wire si,
   output reg so,
   output reg soOe,
   output reg arrCmdValid,
   input wire arrCmdReady,
   output reg [2:0] arrCmdOp,
   output reg [11:0] arrCmdPage,
   output reg [8:0] arrCmdByte,
   output reg arrCmdBuf,
   input wire arrRdValid,
   output wire arrRdReady,
   input wire [7:0] arrRdData,
   input wire arrDone,
   input wire arrMismatch,
   input wire bufRdSel,
   input wire [8:0] bufRdAddr,
   output reg [7:0] bufRdData,
   output wire busy
);

   localparam [3:0] K_NONE = 4'd0;
   localparam [3:0] K_PREAD = 4'd1;
   localparam [3:0] K_BREAD = 4'd2;
   localparam [3:0] K_STAT = 4'd3;
   localparam [3:0] K_BWRITE = 4'd4;
   localparam [3:0] K_PGME = 4'd5;
   localparam [3:0] K_PGM = 4'd6;
   localparam [3:0] K_PERASE = 4'd7;
   localparam [3:0] K_BERASE = 4'd8;
   localparam [3:0] K_CMP = 4'd9;

   localparam [4:0] S_CMD = 5'b00001;
   localparam [4:0] S_STAT = 5'b00010;
   localparam [4:0] S_OUT = 5'b00100;
   localparam [4:0] S_WR = 5'b01000;
   localparam [4:0] S_DROP = 5'b10000;

   function [3:0] opKind;
      input [7:0] op;
      begin
         case (op)
            `OP_PREAD_A, `OP_PREAD_B: opKind = K_PREAD;
            `OP_BRD1_A, `OP_BRD1_B, `OP_BRD2_A, `OP_BRD2_B: opKind = K_BREAD;
            `OP_STAT_A, `OP_STAT_B: opKind = K_STAT;
            `OP_BWR1, `OP_BWR2: opKind = K_BWRITE;
            `OP_PGME1, `OP_PGME2: opKind = K_PGME;
            `OP_PGM1, `OP_PGM2: opKind = K_PGM;
            `OP_PERASE: opKind = K_PERASE;
            `OP_BERASE: opKind = K_BERASE;
            `OP_CMP1, `OP_CMP2: opKind = K_CMP;
            default: opKind = K_NONE;
         endcase
      end
   endfunction

   // Second buffer of each opcode pair
   function bufOf;
      input [7:0] op;
      begin
         case (op)
            `OP_BRD2_A, `OP_BRD2_B, `OP_BWR2, `OP_PGME2, `OP_PGM2, `OP_CMP2: bufOf = 1'b1;
            default: bufOf = 1'b0;
         endcase
      end
   endfunction

   function [9:0] bufIndex;
      input sel;
      input [8:0] a;
      begin
         bufIndex = sel ? (`BUF2_BASE + {1'b0, a}) : {1'b0, a};
      end
   endfunction

   function [8:0] nextAddr;
      input [8:0] a;
      begin
         nextAddr = (a == `BUF_LAST) ? 9'h000 : a + 9'h001;
      end
   endfunction

   reg [7:0] bufMem [0:`BUF_WORDS-1];

   reg sckPrev;
   reg csPrev;
   reg [4:0] state;
   reg [6:0] cnt;
   reg [31:0] frame;
   reg [7:0] opReg;
   reg [3:0] kind;
   reg frameOk;
   reg [11:0] opPage;
   reg [2:0] bitIdx;
   reg [6:0] outShift;
   reg [8:0] bufAddr;
   reg [6:0] wrShift;
   reg readActive;
   reg [11:0] rdPage;
   reg [8:0] rdByte;
   reg pending;
   reg busyFlag;
   reg cmpFlag;
   reg [2:0] statIdx;
   reg [1:0] fifoCnt;
   reg [7:0] fifo0;
   reg [7:0] fifo1;

   wire sckRise = ~csN & sck & ~sckPrev;
   wire sckFall = ~csN & ~sck & sckPrev;
   wire csRise = csN & ~csPrev;
   wire [7:0] opNow = {frame[6:0], si};
   wire [23:0] adrNow = {frame[22:0], si};
   wire [7:0] status = {~busyFlag, cmpFlag, `DENS_CODE, `RSVD_BITS};
   wire wrFire = sckRise & (state == S_WR) & (bitIdx == 3'd7);
   wire byteLoad = sckFall & (state == S_OUT) & (bitIdx == 3'd0);
   wire pop = byteLoad & (kind == K_PREAD) & (fifoCnt != 2'd0);
   wire push = arrRdValid & arrRdReady & readActive;
   wire cmdTake = arrCmdValid & arrCmdReady;
   wire arrayOp = (kind == K_PGME) | (kind == K_PGM) | (kind == K_PERASE) | (kind == K_BERASE) | (kind == K_CMP);
   wire [7:0] bufByte = bufMem[bufIndex(bufOf(opReg), bufAddr)];
   wire [7:0] loadByte = (kind == K_PREAD) ? ((fifoCnt != 2'd0) ? fifo0 : 8'h00) : bufByte;

   assign busy = busyFlag;
   // Stale array data after select rises is drained, never stored
   assign arrRdReady = (fifoCnt != 2'd2) | ~readActive;

   // Buffers: serial writes, engine reads; no reset on storage
   always @(posedge clk_sys) begin
      if (wrFire) begin
         bufMem[bufIndex(bufOf(opReg), bufAddr)] <= {wrShift, si}; // [R17] [R24]
      end
      bufRdData <= bufMem[bufIndex(bufRdSel, bufRdAddr)];
   end

   // Two-entry buffer between array and serial shifter
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         fifoCnt <= 2'd0;
         fifo0 <= 8'h00;
         fifo1 <= 8'h00;
      end else if (csRise) begin
         fifoCnt <= 2'd0;
      end else begin
         case ({push, pop})
            2'b10: begin
               if (fifoCnt == 2'd0) begin
                  fifo0 <= arrRdData;
               end else begin
                  fifo1 <= arrRdData;
               end
               fifoCnt <= fifoCnt + 2'd1;
            end
            2'b01: begin
               fifo0 <= fifo1;
               fifoCnt <= fifoCnt - 2'd1;
            end
            2'b11: begin
               if (fifoCnt == 2'd1) begin
                  fifo0 <= arrRdData;
               end else begin
                  fifo0 <= fifo1;
                  fifo1 <= arrRdData;
               end
            end
            default: begin
               fifoCnt <= fifoCnt;
            end
         endcase
      end
   end

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sckPrev <= 1'b0;
         csPrev <= 1'b1;
         state <= S_CMD;
         cnt <= 7'd0;
         frame <= 32'h0000_0000;
         opReg <= 8'h00;
         kind <= K_NONE;
         frameOk <= 1'b0;
         opPage <= 12'h000;
         bitIdx <= 3'd0;
         outShift <= 7'h00;
         bufAddr <= 9'h000;
         wrShift <= 7'h00;
         readActive <= 1'b0;
         rdPage <= 12'h000;
         rdByte <= 9'h000;
         pending <= 1'b0;
         busyFlag <= 1'b0;
         cmpFlag <= 1'b0;
         statIdx <= 3'd0;
         so <= 1'b0;
         soOe <= 1'b0;
         arrCmdValid <= 1'b0;
         arrCmdOp <= `AOP_READ;
         arrCmdPage <= 12'h000;
         arrCmdByte <= 9'h000;
         arrCmdBuf <= 1'b0;
      end else begin
         sckPrev <= sck;
         csPrev <= csN;
         if (cmdTake) begin
            arrCmdValid <= 1'b0;
            if (arrCmdOp == `AOP_READ) begin
               pending <= 1'b1;
            end
         end
         if (arrRdValid & arrRdReady) begin
            pending <= 1'b0;
         end
         if (arrDone) begin
            busyFlag <= 1'b0; // [R12]
            if (arrCmdOp == `AOP_CMP) begin
               cmpFlag <= arrMismatch; // [R14]
            end
         end
         // One read in flight at a time keeps the buffer from overfilling
         if (readActive & ~arrCmdValid & ~pending & ~cmdTake & (fifoCnt != 2'd2) & ~csN) begin
            arrCmdValid <= 1'b1; // [R05]
            arrCmdOp <= `AOP_READ;
            arrCmdPage <= rdPage;
            arrCmdByte <= rdByte;
            rdByte <= nextAddr(rdByte); // [R04]
         end
         // Poll: bit 7 on the pin tracks busy while the clock is halted
         if ((state == S_STAT) & (statIdx == 3'd1) & soOe) begin
            so <= ~busyFlag; // [R22]
         end
         if (csN & ~csPrev) begin
            // Frame end: outputs released, cut-short frames dropped
            state <= S_CMD;
            soOe <= 1'b0; // [R06]
            readActive <= 1'b0;
            frameOk <= 1'b0;
            if (arrayOp & frameOk & ~busyFlag & ~arrCmdValid) begin
               arrCmdValid <= 1'b1; // [R27]
               busyFlag <= 1'b1; // [R13] [R26]
               arrCmdPage <= opPage;
               arrCmdByte <= 9'h000;
               arrCmdBuf <= bufOf(opReg);
               case (kind)
                  K_PGME: arrCmdOp <= `AOP_ERPROG; // [R18]
                  K_PGM: arrCmdOp <= `AOP_PROG; // [R19]
                  K_PERASE: arrCmdOp <= `AOP_PERASE; // [R20]
                  K_BERASE: arrCmdOp <= `AOP_BERASE; // [R21]
                  default: arrCmdOp <= `AOP_CMP;
               endcase
            end
         end else if (~csN & csPrev) begin
            state <= S_CMD; // [R23]
            cnt <= 7'd0;
            kind <= K_NONE;
            frameOk <= 1'b0;
         end else if (sckRise) begin
            frame <= {frame[30:0], si}; // [R24] [R25]
            if (cnt != `CNT_MAX) begin
               cnt <= cnt + 7'd1;
            end
            case (state)
               S_CMD: begin
                  if (cnt == `CNT_OPC) begin
                     opReg <= opNow;
                     kind <= opKind(opNow);
                     if (opKind(opNow) == K_STAT) begin
                        state <= S_STAT; // [R10]
                        statIdx <= 3'd0;
                     end else if (opKind(opNow) == K_NONE) begin
                        state <= S_DROP;
                     end
                  end
                  if (cnt == `CNT_ADR) begin
                     bufAddr <= adrNow[8:0]; // [R08] [R16]
                     opPage <= (kind == K_BERASE) ? {adrNow[20:12], 3'b000} : adrNow[20:9]; // [R21]
                     frameOk <= 1'b1;
                     if (kind == K_PREAD) begin
                        readActive <= 1'b1; // [R01]
                        rdPage <= adrNow[20:9]; // [R02]
                        rdByte <= adrNow[8:0];
                     end
                     if (kind == K_BWRITE) begin
                        state <= S_WR;
                        bitIdx <= 3'd0;
                     end
                  end
                  if (((cnt == `CNT_BRD) & (kind == K_BREAD)) | ((cnt == `CNT_PRD) & (kind == K_PREAD))) begin
                     state <= S_OUT; // [R01] [R07] [R08]
                     bitIdx <= 3'd0;
                  end
               end
               S_WR: begin
                  wrShift <= {wrShift[5:0], si};
                  bitIdx <= bitIdx + 3'd1;
                  if (bitIdx == 3'd7) begin
                     bufAddr <= nextAddr(bufAddr); // [R17]
                  end
               end
               default: begin
                  state <= state;
               end
            endcase
         end else if (sckFall) begin
            case (state)
               S_STAT: begin
                  soOe <= 1'b1;
                  so <= status[3'd7 - statIdx]; // [R10] [R12] [R15]
                  statIdx <= statIdx + 3'd1; // [R11]
               end
               S_OUT: begin
                  soOe <= 1'b1;
                  bitIdx <= bitIdx + 3'd1; // [R03]
                  if (bitIdx == 3'd0) begin
                     so <= loadByte[7];
                     outShift <= loadByte[6:0];
                     if (kind == K_BREAD) begin
                        bufAddr <= nextAddr(bufAddr); // [R09]
                     end
                  end else begin
                     so <= outShift[6];
                     outShift <= {outShift[5:0], 1'b0};
                  end
               end
               default: begin
                  state <= state;
               end
            endcase
         end
      end
   end

endmodule // serial_flash_command_core

// ==== serial_flash_map.vh ====
// Purpose: constants for the serial flash command core
// Assumes: one serial frame per chip-select low period
// Notes: opcodes, frame bit counts, status layout, array op codes
`ifndef SERIAL_FLASH_MAP_VH
`define SERIAL_FLASH_MAP_VH

`define OP_PREAD_A 8'h52
`define OP_PREAD_B 8'hD2
`define OP_BRD1_A 8'h54
`define OP_BRD1_B 8'hD4
`define OP_BRD2_A 8'h56
`define OP_BRD2_B 8'hD6
`define OP_STAT_A 8'h57
`define OP_STAT_B 8'hD7
`define OP_BWR1 8'h84
`define OP_BWR2 8'h87
`define OP_PGME1 8'h83
`define OP_PGME2 8'h86
`define OP_PGM1 8'h88
`define OP_PGM2 8'h89
`define OP_PERASE 8'h81
`define OP_BERASE 8'h50
`define OP_CMP1 8'h60
`define OP_CMP2 8'h61

// Rising-edge count at which each frame phase completes; CNT_MAX is where the count stops
`define CNT_OPC 7'd7
`define CNT_ADR 7'd31
`define CNT_BRD 7'd39
`define CNT_PRD 7'd63
`define CNT_MAX 7'h7F

`define BUF_LAST 9'd263
`define BUF2_BASE 10'd264
`define BUF_WORDS 528

`define ST_RDY 7
`define ST_CMP 6
// Density code value is arbitrary
`define DENS_CODE 3'b011
`define RSVD_BITS 3'b000

`define AOP_READ 3'h0
`define AOP_ERPROG 3'h1
`define AOP_PROG 3'h2
`define AOP_PERASE 3'h3
`define AOP_BERASE 3'h4
`define AOP_CMP 3'h5

`endif

// ==== tb_top.sv ====
// Purpose: frame level test of the flash command core
// Assumes: sck half period of 3 clk
// Notes: array engine is a behavioural model
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, arst_n, csN, sck, si, cmp;
   wire so, soOe, arrCmdValid, arrCmdReady, arrCmdBuf, arrRdValid, arrRdReady, arrDone;
   wire arrMismatch, bufRdSel, busy;
   wire [2:0] arrCmdOp;
   wire [11:0] arrCmdPage;
   wire [8:0] arrCmdByte, bufRdAddr;
   wire [7:0] arrRdData, bufRdData;
   integer numErrors = 0, samplesChecked = 0, i, k;
   logic [7:0] b;
   logic [7:0] rdOps [0:3] = '{8'h54, 8'hD4, 8'h56, 8'hD6};
   logic [7:0] opTab [0:6] = '{8'h83, 8'h86, 8'h88, 8'h89, 8'h81, 8'h50, 8'h60};
   logic [3:0] expTab [0:6] = '{4'h1, 4'h9, 4'h2, 4'hA, 4'h3, 4'h4, 4'h5};
   serial_flash_command_core dut (.clk_sys(clk_sys), .arst_n(arst_n), .csN(csN), .sck(sck), .si(si),
      .so(so), .soOe(soOe), .arrCmdValid(arrCmdValid), .arrCmdReady(arrCmdReady), .arrCmdOp(arrCmdOp),
      .arrCmdPage(arrCmdPage), .arrCmdByte(arrCmdByte), .arrCmdBuf(arrCmdBuf), .arrRdValid(arrRdValid),
      .arrRdReady(arrRdReady), .arrRdData(arrRdData), .arrDone(arrDone), .arrMismatch(arrMismatch),
      .bufRdSel(bufRdSel), .bufRdAddr(bufRdAddr), .bufRdData(bufRdData), .busy(busy));
   flash_array_model model (.clk_sys(clk_sys), .arst_n(arst_n), .arrCmdValid(arrCmdValid),
      .arrCmdReady(arrCmdReady), .arrCmdOp(arrCmdOp), .arrCmdPage(arrCmdPage), .arrCmdByte(arrCmdByte),
      .arrCmdBuf(arrCmdBuf), .arrRdValid(arrRdValid), .arrRdReady(arrRdReady), .arrRdData(arrRdData),
      .arrDone(arrDone), .arrMismatch(arrMismatch), .bufRdSel(bufRdSel), .bufRdAddr(bufRdAddr));
   task automatic tick(input integer n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic chkVal(input [15:0] got, input [15:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         numErrors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic sbit(input logic d, output logic q);
      sck = 1'b0;
      si = d;
      tick(3);
      q = so;
      sck = 1'b1;
      tick(3);
   endtask
   task automatic send(input [63:0] v, input integer n);
      logic q;
      for (int j = n - 1; j >= 0; j--) sbit(v[j], q);
   endtask
   task automatic getByte(output [7:0] v);
      for (int j = 7; j >= 0; j--) sbit(1'b0, v[j]);
   endtask
   task automatic open(input [63:0] v, input integer n);
      csN = 1'b0;
      tick(2);
      send(v, n);
   endtask
   task automatic close;
      sck = 1'b0;
      tick(3);
      csN = 1'b1;
      tick(4);
   endtask
   task automatic status(input [7:0] op, input [7:0] exp);
      open(op, 8);
      getByte(b);
      chkVal(b, exp);
      getByte(b);
      chkVal(b, exp);
      close;
   endtask
   task automatic done(input string s);
      $display("Test %s finished", s);
   endtask
   task automatic summarize;
      $display("Checks %0d, mismatches %0d", samplesChecked, numErrors);
      if (numErrors == 0 && samplesChecked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      arst_n = 1'b0;
      csN = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      cmp = 1'b0;
      tick(10);
      arst_n = 1'b1;
      tick(4);
      chkVal(soOe, 1'b0);
      status(8'h57, 8'h98);
      done("reset");
      open({8'h84, 15'h0, 9'd262}, 32);
      send(24'hA1B2C3, 24);
      close;
      chkVal(bufRdData, 8'hA1);
      open({8'h87, 15'h0, 9'd262}, 32);
      send(8'h5A, 8);
      close;
      done("buffer write");
      for (i = 0; i < 2; i++) begin
         k = i ? 12'h3F1 : 12'hA5C;
         open({i ? 8'hD2 : 8'h52, 3'b0, k[11:0], 9'd263, 32'h0}, 64);
         getByte(b);
         chkVal(b, k[7:0] + 8'h07);
         getByte(b);
         chkVal(b, k[7:0]);
         close;
         chkVal(soOe, 1'b0);
      end
      done("page read");
      for (i = 0; i < 4; i++) begin
         open({rdOps[i], 15'h0, 9'd262, 8'h0}, 40);
         getByte(b);
         chkVal(b, i < 2 ? 8'hA1 : 8'h5A);
         if (i == 0) begin
            getByte(b);
            chkVal(b, 8'hB2);
            getByte(b);
            chkVal(b, 8'hC3);
         end
         close;
      end
      done("buffer read");
      for (i = 0; i < 7; i++) begin
         open({opTab[i], 24'h187000}, 32);
         close;
         status(8'hD7, {1'b0, cmp, 6'h18});
         chkVal(busy, 1'b1);
         open(8'hD7, 8);
         sck = 1'b0;
         tick(3);
         chkVal(so, 1'b0);
         // Wait out the op before the next array command
         for (k = 0; k < 600 && so !== 1'b1; k++) tick(1);
         chkVal(so, 1'b1);
         if (k == 600)
            summarize;
         close;
         chkVal(busy, 1'b0);
         chkVal({(i < 4 || i == 6) ? model.lastBuf : 1'b0, model.lastOp, model.lastPage},
            {expTab[i], 12'hC38});
         if (i == 6)
            cmp = 1'b1;
      end
      done("program and erase");
      k = model.opCount;
      open({8'h81, 10'h0}, 18);
      close;
      tick(20);
      chkVal(model.opCount, k[15:0]);
      status(8'h57, 8'hD8);
      done("short frame");
      summarize;
   end
endmodule // tb_top
